// ===== src/spr_pkg.sv
`default_nettype none
package spr_pkg;

   localparam int unsigned SPR_NUM_SEG = 8;
   localparam int unsigned SPR_NUM_CTR = 4;

   // register byte addresses on the apb
   localparam logic [7:0] SPR_ADDR_ROUTE  = 8'h00;
   localparam logic [7:0] SPR_ADDR_LIMIT0 = 8'h04;
   localparam logic [7:0] SPR_ADDR_LIMIT1 = 8'h08;
   localparam logic [7:0] SPR_ADDR_LIMIT2 = 8'h0c;
   localparam logic [7:0] SPR_ADDR_LIMIT3 = 8'h10;
   localparam logic [7:0] SPR_ADDR_COUNT0 = 8'h14;
   localparam logic [7:0] SPR_ADDR_COUNT1 = 8'h18;
   localparam logic [7:0] SPR_ADDR_COUNT2 = 8'h1c;
   localparam logic [7:0] SPR_ADDR_COUNT3 = 8'h20;

   // reset values and writable bits
   localparam logic [31:0] SPR_ROUTE_RESET = 32'h0000_0000;
   localparam logic [31:0] SPR_LIMIT_RESET = 32'h0000_0000;
   localparam logic [31:0] SPR_ROUTE_MASK  = 32'h0000_ffff;
   localparam logic [31:0] SPR_LIMIT_MASK  = 32'hffff_00f3;

   // field positions
   localparam int unsigned SPR_ROUTE_W     = 2;
   localparam int unsigned SPR_WCAP_LSB    = 24;
   localparam int unsigned SPR_RCAP_LSB    = 16;
   localparam int unsigned SPR_MEMTYPE_LSB = 4;
   localparam int unsigned SPR_ALIGN_LSB   = 0;
   localparam int unsigned SPR_CNT_WR_LSB  = 8;
   localparam int unsigned SPR_CNT_RD_LSB  = 0;

   // largest legal cap-less-one values
   localparam logic [7:0] SPR_WCAP_MAX = 8'h1f;
   localparam logic [7:0] SPR_RCAP_MAX = 8'h3f;

   // returns {read cache, write cache}; reserved codes fall back to device non-bufferable
   function automatic logic [7:0] spr_cache_map(input logic [3:0] mt);
      logic [7:0] r;
      r = 8'h00;
      case (mt)
         4'h0:    r = 8'h00;
         4'h1:    r = 8'h11;
         4'h2:    r = 8'h22;
         4'h3:    r = 8'h33;
         4'h4:    r = 8'ha6;
         4'h5:    r = 8'he6;
         4'h6:    r = 8'hae;
         4'h7:    r = 8'hee;
         4'h8:    r = 8'hb7;
         4'h9:    r = 8'hf7;
         4'ha:    r = 8'hbf;
         4'hb:    r = 8'hff;
         default: r = 8'h00;
      endcase
      return r;
   endfunction : spr_cache_map

   // burst-split boundary in bytes; reserved code behaves as the smallest
   function automatic logic [8:0] spr_boundary(input logic [1:0] al);
      logic [8:0] b;
      b = 9'h040;
      case (al)
         2'h1:    b = 9'h080;
         2'h2:    b = 9'h100;
         default: b = 9'h040;
      endcase
      return b;
   endfunction : spr_boundary

endpackage : spr_pkg
`default_nettype wire

// ===== src/spr_router.sv
`default_nettype none
module spr_router (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // segment requests
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic [2:0]  req_segment,
   input  wire logic [31:0] req_addr,
   // first master port issue
   output logic             m0_valid,
   input  wire logic        m0_ready,
   output logic             m0_write,
   output logic [31:0]      m0_addr,
   output logic             m0_counter,
   output logic [3:0]       m0_arcache,
   output logic [3:0]       m0_awcache,
   output logic [8:0]       m0_boundary,
   // first master port completions
   input  wire logic        m0_done_valid,
   input  wire logic        m0_done_write,
   input  wire logic        m0_done_counter,
   // second master port issue
   output logic             m1_valid,
   input  wire logic        m1_ready,
   output logic             m1_write,
   output logic [31:0]      m1_addr,
   output logic             m1_counter,
   output logic [3:0]       m1_arcache,
   output logic [3:0]       m1_awcache,
   output logic [8:0]       m1_boundary,
   // second master port completions
   input  wire logic        m1_done_valid,
   input  wire logic        m1_done_write,
   input  wire logic        m1_done_counter
);

   logic [31:0] route_q;
   logic [31:0] limit_q   [4];
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic [31:0] rd_data;
   logic        hit;
   logic        wr_en;

   logic [1:0]  sel;
   logic        port;
   logic [3:0]  rd_full;
   logic [3:0]  wr_full;
   logic [6:0]  rd_cnt    [4];
   logic [6:0]  wr_cnt    [4];
   logic        cap_ok;
   logic        slot_free;
   logic        issue;
   logic [3:0]  done_rd;
   logic [3:0]  done_wr;
   logic [1:0]  mr;
   logic [1:0]  dv;
   logic [1:0]  dw;
   logic [1:0]  dc;

   logic [1:0]  mv_q;
   logic [1:0]  mw_q;
   logic [1:0]  mc_q;
   logic [31:0] ma_q      [2];
   logic [7:0]  mcache_q  [2];
   logic [8:0]  mb_q      [2];

   // register decode; the read word is captured in the setup cycle so that
   // prdata comes from a flop while pready can stay high
   always_comb begin
      hit     = 1'b1;
      rd_data = 32'h0000_0000;
      case (paddr)
         spr_pkg::SPR_ADDR_ROUTE:  rd_data = route_q & spr_pkg::SPR_ROUTE_MASK;
         spr_pkg::SPR_ADDR_LIMIT0: rd_data = limit_q[0] & spr_pkg::SPR_LIMIT_MASK;
         spr_pkg::SPR_ADDR_LIMIT1: rd_data = limit_q[1] & spr_pkg::SPR_LIMIT_MASK;
         spr_pkg::SPR_ADDR_LIMIT2: rd_data = limit_q[2] & spr_pkg::SPR_LIMIT_MASK;
         spr_pkg::SPR_ADDR_LIMIT3: rd_data = limit_q[3] & spr_pkg::SPR_LIMIT_MASK;
         spr_pkg::SPR_ADDR_COUNT0: rd_data = {17'h0, wr_cnt[0], 1'b0, rd_cnt[0]};
         spr_pkg::SPR_ADDR_COUNT1: rd_data = {17'h0, wr_cnt[1], 1'b0, rd_cnt[1]};
         spr_pkg::SPR_ADDR_COUNT2: rd_data = {17'h0, wr_cnt[2], 1'b0, rd_cnt[2]};
         spr_pkg::SPR_ADDR_COUNT3: rd_data = {17'h0, wr_cnt[3], 1'b0, rd_cnt[3]};
         default:                  hit = 1'b0;
      endcase
   end

   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & psel & penable;
   assign wr_en   = psel & penable & pwrite & pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr_q <= !hit;
      end
   end

   // count registers are read-only, writes to them are silently dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= spr_pkg::SPR_ROUTE_RESET;
      end else if (wr_en && paddr == spr_pkg::SPR_ADDR_ROUTE) begin
         route_q <= pwdata & spr_pkg::SPR_ROUTE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            limit_q[i] <= spr_pkg::SPR_LIMIT_RESET;
         end
      end else if (wr_en) begin
         // same layout for all four limit sets
         if (paddr == spr_pkg::SPR_ADDR_LIMIT0) limit_q[0] <= pwdata & spr_pkg::SPR_LIMIT_MASK;
         if (paddr == spr_pkg::SPR_ADDR_LIMIT1) limit_q[1] <= pwdata & spr_pkg::SPR_LIMIT_MASK;
         if (paddr == spr_pkg::SPR_ADDR_LIMIT2) limit_q[2] <= pwdata & spr_pkg::SPR_LIMIT_MASK;
         if (paddr == spr_pkg::SPR_ADDR_LIMIT3) limit_q[3] <= pwdata & spr_pkg::SPR_LIMIT_MASK;
      end
   end

   // routing: the selector value is the counter, its top bit the port
   assign sel  = route_q[{req_segment, 1'b0} +: spr_pkg::SPR_ROUTE_W];
   assign port = sel[1];
   assign mr   = {m1_ready, m0_ready};
   assign dv   = {m1_done_valid, m0_done_valid};
   assign dw   = {m1_done_write, m0_done_write};
   assign dc   = {m1_done_counter, m0_done_counter};

   assign cap_ok    = req_write ? !wr_full[sel] : !rd_full[sel];
   // one holding slot per port; a port that is draining takes the next request
   assign slot_free = !mv_q[port] || mr[port];
   assign req_ready = cap_ok && slot_free;
   assign issue     = req_valid && req_ready;

   always_comb begin
      done_rd = 4'h0;
      done_wr = 4'h0;
      for (int p = 0; p < 2; p++) begin
         if (dv[p]) begin
            if (dw[p]) done_wr[2 * p + int'(dc[p])] = 1'b1;
            else       done_rd[2 * p + int'(dc[p])] = 1'b1;
         end
      end
   end

   for (genvar c = 0; c < 4; c++) begin : g_trk
      spr_tracker u_trk (
         .clk       (pclk),
         .rst_n     (presetn),
         .issue_rd  (issue && !req_write && sel == 2'(c)),
         .issue_wr  (issue && req_write && sel == 2'(c)),
         .done_rd   (done_rd[c]),
         .done_wr   (done_wr[c]),
         .rd_cap_m1 (limit_q[c][spr_pkg::SPR_RCAP_LSB +: 8]),
         .wr_cap_m1 (limit_q[c][spr_pkg::SPR_WCAP_LSB +: 8]),
         .rd_full   (rd_full[c]),
         .wr_full   (wr_full[c]),
         .rd_count  (rd_cnt[c]),
         .wr_count  (wr_cnt[c])
      );
   end

   // issue stage; attributes are frozen at issue so a later limit write
   // cannot change a transaction already waiting on the port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mv_q <= 2'h0;
         mw_q <= 2'h0;
         mc_q <= 2'h0;
         for (int p = 0; p < 2; p++) begin
            ma_q[p]     <= 32'h0000_0000;
            mcache_q[p] <= 8'h00;
            mb_q[p]     <= 9'h040;
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (issue && port == 1'(p)) begin
               mv_q[p]     <= 1'b1;
               mw_q[p]     <= req_write;
               mc_q[p]     <= sel[0];
               ma_q[p]     <= req_addr;
               mcache_q[p] <= spr_pkg::spr_cache_map(
                  limit_q[sel][spr_pkg::SPR_MEMTYPE_LSB +: 4]);
               mb_q[p]     <= spr_pkg::spr_boundary(
                  limit_q[sel][spr_pkg::SPR_ALIGN_LSB +: 2]);
            end else if (mr[p]) begin
               mv_q[p] <= 1'b0;
            end
         end
      end
   end

   assign m0_valid    = mv_q[0];
   assign m0_write    = mw_q[0];
   assign m0_counter  = mc_q[0];
   assign m0_addr     = ma_q[0];
   assign m0_arcache  = mcache_q[0][7:4];
   assign m0_awcache  = mcache_q[0][3:0];
   assign m0_boundary = mb_q[0];
   assign m1_valid    = mv_q[1];
   assign m1_write    = mw_q[1];
   assign m1_counter  = mc_q[1];
   assign m1_addr     = ma_q[1];
   assign m1_arcache  = mcache_q[1][7:4];
   assign m1_awcache  = mcache_q[1][3:0];
   assign m1_boundary = mb_q[1];

   chk_route_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> route_q == 32'h0000_0000)
      else $error("routing selectors not zero after reset");

   chk_limit_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> limit_q[0][31:16] == 16'h0000 && limit_q[3][31:16] == 16'h0000)
      else $error("caps not zero after reset");

   chk_route_field: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == spr_pkg::SPR_ADDR_ROUTE
      |=> route_q[15:14] == $past(pwdata[15:14]) && route_q[1:0] == $past(pwdata[1:0]))
      else $error("routing write did not land");

   chk_route_resvd: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == spr_pkg::SPR_ADDR_ROUTE
      |=> prdata[31:16] == 16'h0000 && prdata[15:0] == route_q[15:0])
      else $error("routing readback wrong");

   chk_sel0_port: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h0 |=> m0_valid && !m0_counter)
      else $error("selector 0 not on port zero counter 0");

   chk_sel1_port: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h1 |=> m0_valid && m0_counter)
      else $error("selector 1 not on port zero counter 1");

   chk_sel2_port: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h2 |=> m1_valid && !m1_counter)
      else $error("selector 2 not on port one counter 2");

   chk_sel3_port: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h3 |=> m1_valid && m1_counter)
      else $error("selector 3 not on port one counter 3");

   // stall checks follow whichever counter the request selects
   chk_write_stall: assert property (@(posedge pclk) disable iff (!presetn)
      req_valid && req_write && limit_q[sel][31:24] <= 8'h1f
      && {1'b0, wr_cnt[sel]} == limit_q[sel][31:24] + 8'h01 |-> !req_ready)
      else $error("write issued past its cap");

   chk_read_stall: assert property (@(posedge pclk) disable iff (!presetn)
      req_valid && !req_write && limit_q[sel][23:16] <= 8'h3f
      && {1'b0, rd_cnt[sel]} == limit_q[sel][23:16] + 8'h01 |-> !req_ready)
      else $error("read issued past its cap");

   chk_cache_map: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h0 && limit_q[0][7:4] == 4'h4
      |=> m0_arcache == 4'ha && m0_awcache == 4'h6)
      else $error("attribute code mapped wrongly");

   chk_bound_map: assert property (@(posedge pclk) disable iff (!presetn)
      issue && sel == 2'h0 && limit_q[0][1:0] == 2'h2
      |=> m0_boundary == 9'h100)
      else $error("alignment code mapped wrongly");

   chk_route_upper: assert property (@(posedge pclk) disable iff (!presetn)
      route_q[31:16] == 16'h0000)
      else $error("reserved routing bits not zero");

   chk_slot_hold: assert property (@(posedge pclk) disable iff (!presetn)
      m0_valid && !m0_ready |=> m0_valid && $stable(m0_addr))
      else $error("port zero request dropped before acceptance");

endmodule : spr_router
`default_nettype wire

// ===== src/spr_tracker.sv
`default_nettype none
module spr_tracker (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // events
   input  wire logic       issue_rd,
   input  wire logic       issue_wr,
   input  wire logic       done_rd,
   input  wire logic       done_wr,
   // programmed caps, less one
   input  wire logic [7:0] rd_cap_m1,
   input  wire logic [7:0] wr_cap_m1,
   // state
   output logic            rd_full,
   output logic            wr_full,
   output logic [6:0]      rd_count,
   output logic [6:0]      wr_count
);

   logic [6:0] rd_q;
   logic [6:0] wr_q;
   logic [7:0] rd_cap;
   logic [7:0] wr_cap;

   // out-of-range programming is clamped so the counters cannot overflow
   assign rd_cap  = (rd_cap_m1 > spr_pkg::SPR_RCAP_MAX) ? spr_pkg::SPR_RCAP_MAX : rd_cap_m1;
   assign wr_cap  = (wr_cap_m1 > spr_pkg::SPR_WCAP_MAX) ? spr_pkg::SPR_WCAP_MAX : wr_cap_m1;
   assign rd_full = {1'b0, rd_q} > rd_cap;
   assign wr_full = {1'b0, wr_q} > wr_cap;
   assign rd_count = rd_q;
   assign wr_count = wr_q;

   // a stray completion at zero is dropped rather than wrapping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 7'h00;
      end else begin
         rd_q <= rd_q + {6'h00, issue_rd} - {6'h00, done_rd && rd_q != 7'h00};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 7'h00;
      end else begin
         wr_q <= wr_q + {6'h00, issue_wr} - {6'h00, done_wr && wr_q != 7'h00};
      end
   end

   chk_count_up: assert property (@(posedge clk) disable iff (!rst_n)
      issue_wr && !done_wr |=> wr_q == $past(wr_q) + 7'h01)
      else $error("write count did not rise on issue");

   chk_count_down: assert property (@(posedge clk) disable iff (!rst_n)
      done_rd && !issue_rd && rd_q != 7'h00 |=> rd_q == $past(rd_q) - 7'h01)
      else $error("read count did not fall on completion");

endmodule : spr_tracker
`default_nettype wire

// ===== tb/spr_far_model.sv
`default_nettype none
// far side of one master port: takes issues, returns one completion per issue
module spr_far_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // issue side
   input  wire logic valid,
   output logic      ready,
   input  wire logic write,
   input  wire logic counter,
   // completions
   output logic      done_valid,
   output logic      done_write,
   output logic      done_counter,
   // bench controls: slow halves ready, hold parks completions
   input  wire logic slow,
   input  wire logic hold
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] pend_q [$];
   logic       tick_q;

   assign ready = !slow || tick_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q.delete();
         tick_q <= 1'b0;
         done_valid <= 1'b0;
         done_write <= 1'b0;
         done_counter <= 1'b0;
      end else begin
         tick_q <= !tick_q;
         if (valid && ready) begin
            pend_q.push_back({write, counter});
         end
         if (!hold && pend_q.size() > 0) begin
            done_valid <= 1'b1;
            {done_write, done_counter} <= pend_q.pop_front();
         end else begin
            // idle lines toggle every cycle rather than hold the last completion
            done_valid <= 1'b0;
            {done_write, done_counter} <= ~{done_write, done_counter};
         end
      end
   end
endmodule : spr_far_model
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [7:0]  paddr       = 8'h00;
   logic [31:0] pwdata      = 32'h0;
   logic        req_valid   = 1'b0;
   logic        req_write   = 1'b0;
   logic [2:0]  req_segment = 3'h0;
   logic [31:0] req_addr    = 32'h0;
   logic        slow        = 1'b0;
   logic [1:0]  hold        = 2'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        req_ready;
   // per-port vectors have two drivers each, one per bit, so they are nets
   wire logic [1:0]  mv, mr, mw, mc, dv, dw, dc;
   wire logic [31:0] ma [2];
   wire logic [3:0]  arc [2];
   wire logic [3:0]  awc [2];
   wire logic [8:0]  mb [2];
   int          failures     = 0;
   int          total_checks = 0;
   logic [7:0]  exp_cache [4];
   logic [8:0]  exp_bnd [4];
   logic [7:0]  cache_tab [12] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'ha6, 8'he6,
                                   8'hae, 8'hee, 8'hb7, 8'hf7, 8'hbf, 8'hff};

   always #12.5 pclk = ~pclk;

   spr_router dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_segment(req_segment), .req_addr(req_addr),
      .m0_valid(mv[0]), .m0_ready(mr[0]), .m0_write(mw[0]), .m0_addr(ma[0]),
      .m0_counter(mc[0]), .m0_arcache(arc[0]), .m0_awcache(awc[0]), .m0_boundary(mb[0]),
      .m0_done_valid(dv[0]), .m0_done_write(dw[0]), .m0_done_counter(dc[0]),
      .m1_valid(mv[1]), .m1_ready(mr[1]), .m1_write(mw[1]), .m1_addr(ma[1]),
      .m1_counter(mc[1]), .m1_arcache(arc[1]), .m1_awcache(awc[1]), .m1_boundary(mb[1]),
      .m1_done_valid(dv[1]), .m1_done_write(dw[1]), .m1_done_counter(dc[1])
   );

   for (genvar g = 0; g < 2; g++) begin : g_far
      spr_far_model far_u (
         .clk(pclk), .rst_n(presetn), .valid(mv[g]), .ready(mr[g]), .write(mw[g]),
         .counter(mc[g]), .done_valid(dv[g]), .done_write(dw[g]), .done_counter(dc[g]),
         .slow(slow), .hold(hold[g])
      );
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is tied high, so this wait ends after one cycle; the watchdog covers a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0, d, e);
      chk(what, {exp[30:0], exp_err}, {d[30:0], e});
      chk(what, exp, d);
   endtask : reg_chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, a, v, d, e);
   endtask : wr_reg

   task automatic set_limit(input logic [1:0] c, input logic [31:0] v);
      logic [7:0] a;
      a = spr_pkg::SPR_ADDR_LIMIT0 + {4'h0, c, 2'h0};
      wr_reg(a, v);
      reg_chk("limit readback", a, v & 32'hffff_00f3, 1'b0);
      exp_cache[c] = (v[7:4] < 4'hc) ? cache_tab[v[7:4]] : 8'h00;
      exp_bnd[c] = (v[1:0] == 2'h1) ? 9'h080 : (v[1:0] == 2'h2) ? 9'h100 : 9'h040;
   endtask : set_limit

   // route word is 0xe4e4 throughout, so segment s uses counter s mod 4
   task automatic issue(input logic [2:0] seg, input logic wr, input logic [31:0] a);
      logic [1:0] c;
      logic       p;
      c = seg[1:0];
      p = c[1];
      @(posedge pclk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_segment <= seg;
      req_addr <= a;
      do begin
         @(posedge pclk);
      end while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      do begin
         @(posedge pclk);
      end while (!(mv[p] === 1'b1 && mr[p] === 1'b1));
      chk("issue fields", {12'h0, 1'b1, wr, c[0], exp_cache[c], exp_bnd[c]},
          {12'h0, mv[p] & mr[p], mw[p], mc[p], arc[p], awc[p], mb[p]});
      chk("issue addr", a, ma[p]);
   endtask : issue

   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      give_verdict();
   end

   initial begin
      int n;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         reg_chk("reset value", 8'(4 * i), 32'h0, 1'b0);
      end
      reg_chk("unmapped", 8'h40, 32'h0, 1'b1);
      wr_reg(spr_pkg::SPR_ADDR_COUNT0, 32'hffff_ffff);
      reg_chk("count read only", spr_pkg::SPR_ADDR_COUNT0, 32'h0, 1'b0);
      set_limit(2'h2, 32'hffff_ffff);
      wr_reg(spr_pkg::SPR_ADDR_ROUTE, 32'hffff_e4e4);
      reg_chk("route word", spr_pkg::SPR_ADDR_ROUTE, 32'h0000_e4e4, 1'b0);
      // every memtype code once, every alignment code on every counter
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            set_limit(2'(c), {24'h0, 4'(4 * r + c), 2'h3, 2'(r + c)});
         end
         slow <= (r == 1);
         for (int s = 0; s < 8; s++) begin
            issue(3'(s), 1'(s + r), {8'h5a, 21'(s), 3'(r)});
         end
      end
      slow <= 1'b0;
      repeat (10) @(posedge pclk);
      set_limit(2'h1, 32'h0002_0000);
      // three reads, then one write, allowed on counter 1 before a stall
      for (int d = 0; d < 2; d++) begin
         hold <= 2'h1;
         for (int i = 0; i < (d ? 1 : 3); i++) begin
            issue(3'h1, 1'(d), 32'h100 + 32'(i));
         end
         reg_chk("count at cap", spr_pkg::SPR_ADDR_COUNT1, d ? 32'h100 : 32'h3, 1'b0);
         @(posedge pclk);
         req_valid <= 1'b1;
         req_write <= 1'(d);
         req_segment <= 3'h1;
         repeat (8) begin
            @(posedge pclk);
            chk("stall at cap", 32'h0, {31'h0, req_ready});
         end
         hold <= 2'h0;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (req_ready !== 1'b1 && n < 20);
         chk("resume after done", 32'h1, {31'h0, req_ready});
         req_valid <= 1'b0;
         repeat (10) @(posedge pclk);
         reg_chk("count drained", spr_pkg::SPR_ADDR_COUNT1, 32'h0, 1'b0);
      end
      // mid-run reset must clear what was programmed above
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      reg_chk("route after reset", spr_pkg::SPR_ADDR_ROUTE, 32'h0, 1'b0);
      reg_chk("limit after reset", spr_pkg::SPR_ADDR_LIMIT1, 32'h0, 1'b0);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
